// ==== src/bccf_core.sv ====
// bccf_core: condition-code flags, evaluation and register slave
module bccf_core
	import bccf_pkg::*;
#(
	parameter logic [15:0] TMO_CYC_0 = 16'(TMO0_US * 1000 / CLK_PERIOD_NS),
	parameter logic [15:0] TMO_CYC_1 = 16'(TMO1_US * 1000 / CLK_PERIOD_NS),
	parameter logic [15:0] TMO_CYC_2 = 16'(TMO2_US * 1000 / CLK_PERIOD_NS),
	parameter logic [15:0] TMO_CYC_3 = 16'(TMO3_US * 1000 / CLK_PERIOD_NS)
)(
	input  wire logic                  sys_clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic [AVS_ADDR_W-1:0] avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	input  wire logic [3:0]            avs_byteenable_i,
	output logic [31:0]                avs_readdata_o,
	output logic                       avs_waitrequest_o,
	input  wire logic [4:0]            cond_sel_i,
	output logic                       cond_true_o,
	output logic                       cond_known_o,
	input  wire bccf_flag_op_t         flag_op_i,
	input  wire bccf_msg_t             msg_i,
	output logic                       irq_o
);
	bccf_bus_st_t      bus_st_ff;
	logic [31:0]       rdata_ff;
	logic [15:0]       cfg_ff;
	logic [5:0]        gp_ff;
	bccf_outcome_t     outc_ff;
	logic [IRQ_W-1:0]  irq_stat_ff;
	logic [IRQ_W-1:0]  irq_mask_ff;
	logic              cond_true_ff;
	logic              cond_known_ff;
	logic [7:0]        idx;
	logic              req;
	logic              wr_go;
	logic [15:0]       wdata_be;
	logic [15:0]       tmo_cycles;
	bccf_outcome_t     outc_new;
	logic [15:0]       cc_vec;
	logic [5:0]        nxt_gp;
	logic [IRQ_W-1:0]  irq_ev;
	logic [IRQ_W-1:0]  nxt_irq_stat;

	// set and clear together toggle, so one argument covers all three actions
	function automatic logic [5:0] gp_apply(input logic [5:0] cur, input logic [15:0] arg);
		logic [5:0] s;
		logic [5:0] c;
		s = arg[FLG_SET_LSB +: 6];
		c = arg[FLG_CLR_LSB +: 6];
		gp_apply = (cur & ~(s | c)) | (s & ~c) | ((s & c) & ~cur);
	endfunction

	function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be);
		be_merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] i, input logic [15:0] cfg,
		input logic [15:0] cc, input logic [IRQ_W-1:0] st, input logic [IRQ_W-1:0] mk);
		case (i)
			IDX_BC_CFG:   reg_read = {16'h0000, cfg};
			IDX_GP_FLAGS: reg_read = {16'h0000, cc};
			IDX_IRQ_STAT: reg_read = {{(32-IRQ_W){1'b0}}, st};
			IDX_IRQ_MASK: reg_read = {{(32-IRQ_W){1'b0}}, mk};
			default:      reg_read = 32'h0000_0000;
		endcase
	endfunction

	assign idx      = avs_address_i[AVS_ADDR_W-1:2];
	assign req      = avs_read_i || avs_write_i;
	assign wr_go    = avs_write_i && (bus_st_ff == BUS_ACK);
	assign wdata_be = be_merge(16'h0000, avs_writedata_i[15:0], avs_byteenable_i[1:0]);

	// one wait cycle per access; read data is latched in that cycle
	assign avs_waitrequest_o = req && (bus_st_ff != BUS_ACK);
	assign avs_readdata_o    = rdata_ff;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_st_ff <= BUS_IDLE;
		end else begin
			case (bus_st_ff)
				BUS_IDLE: bus_st_ff <= req ? BUS_ACK : BUS_IDLE;
				BUS_ACK:  bus_st_ff <= BUS_IDLE;
				default:  bus_st_ff <= BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read_i && bus_st_ff == BUS_IDLE) begin
			rdata_ff <= reg_read(idx, cfg_ff, cc_vec, irq_stat_ff, irq_mask_ff);
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_ff <= CFG_RST;
		end else if (wr_go && idx == IDX_BC_CFG) begin
			cfg_ff <= be_merge(cfg_ff, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
		end
	end

	// the sequencer's op lands first, a host write in the same cycle on top of it
	always_comb begin
		nxt_gp = gp_ff;
		if (flag_op_i.valid) begin
			nxt_gp = gp_apply(nxt_gp, flag_op_i.arg);
		end
		if (wr_go && idx == IDX_GP_FLAGS) begin
			nxt_gp = gp_apply(nxt_gp, wdata_be);
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gp_ff <= GP_RST;
		end else begin
			gp_ff <= nxt_gp;
		end
	end

	always_comb begin
		case (cfg_ff[CFG_TMO_HI:CFG_TMO_LO])
			2'b00:   tmo_cycles = TMO_CYC_0;
			2'b01:   tmo_cycles = TMO_CYC_1;
			2'b10:   tmo_cycles = TMO_CYC_2;
			default: tmo_cycles = TMO_CYC_3;
		endcase
	end

	bccf_msg_eval u_eval (
		.msg_i           (msg_i),
		.tmo_cycles_i    (tmo_cycles),
		.bcast_mask_en_i (cfg_ff[CFG_BCAST_EN]),
		.outc_o          (outc_new)
	);

	// outcome flags are a snapshot of the last finished message
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			outc_ff <= '0;
		end else if (msg_i.done) begin
			outc_ff <= outc_new;
		end
	end

	// codes 0, 1 and 12-15 belong to other logic and read as zero here
	assign cc_vec = {4'h0, outc_ff.masked_status_flag, outc_ff.good_block_flag,
		outc_ff.format_error_flag, outc_ff.no_reply_flag, gp_ff, 2'b00};

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cond_true_ff  <= 1'b0;
			cond_known_ff <= 1'b0;
		end else begin
			cond_true_ff  <= cc_vec[cond_sel_i[3:0]] ^ cond_sel_i[CC_INV_BIT];
			cond_known_ff <= (cond_sel_i[3:0] >= CC_GP_FIRST) && (cond_sel_i[3:0] <= CC_MASKED);
		end
	end

	assign cond_true_o  = cond_true_ff;
	assign cond_known_o = cond_known_ff;

	assign irq_ev[IRQ_DONE]     = msg_i.done;
	assign irq_ev[IRQ_NO_REPLY] = msg_i.done && outc_new.no_reply_flag;
	assign irq_ev[IRQ_FMT_ERR]  = msg_i.done && outc_new.format_error_flag;
	assign irq_ev[IRQ_MASKED]   = msg_i.done && outc_new.masked_status_flag;

	// a new event wins over a write-one clear in the same cycle
	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (wr_go && idx == IDX_IRQ_STAT) begin
			nxt_irq_stat = irq_stat_ff & ~wdata_be[IRQ_W-1:0];
		end
		nxt_irq_stat = nxt_irq_stat | irq_ev;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_mask_ff <= '0;
		end else if (wr_go && idx == IDX_IRQ_MASK) begin
			irq_mask_ff <= wdata_be[IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_stat_ff & irq_mask_ff);

	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	logic host_gp_wr;
	assign host_gp_wr = wr_go && idx == IDX_GP_FLAGS;

	sequence s_done_ok;
		msg_i.done && msg_i.reply_seen && msg_i.reply_gap <= tmo_cycles;
	endsequence

	sequence s_done_tx_clean;
		s_done_ok and (!msg_i.word_err
		&& msg_i.status_word[ST_RT_HI:ST_RT_LO] == msg_i.rt_addr
		&& (msg_i.kind == MK_RT_TO_BC || msg_i.kind == MK_RT_TO_RT
		|| msg_i.kind == MK_MODE_TX_DATA));
	endsequence

	sequence s_bus_access;
		req && avs_waitrequest_o ##1 req && !avs_waitrequest_o;
	endsequence

	property p_cond_eval;
		(cond_sel_i[3:0] >= CC_GP_FIRST && cond_sel_i[3:0] <= CC_MASKED)
		|=> cond_known_o && (cond_true_o == ($past(cc_vec[cond_sel_i[3:0]]) ^ $past(cond_sel_i[4])));
	endproperty
	a_cond_eval: assert property (p_cond_eval) else $error("condition result wrong");

	property p_gp_select;
		(cond_sel_i == {1'b0, CC_GP_FIRST} && !flag_op_i.valid && !host_gp_wr)
		|=> cond_true_o == gp_ff[0];
	endproperty
	a_gp_select: assert property (p_gp_select) else $error("flag two not selected");

	property p_flag_op_set;
		(flag_op_i.valid && flag_op_i.arg[FLG_SET_LSB] && !flag_op_i.arg[FLG_CLR_LSB]
		&& !host_gp_wr) |=> gp_ff[0];
	endproperty
	a_flag_op_set: assert property (p_flag_op_set) else $error("flag op set lost");

	property p_flag_op_tgl;
		(flag_op_i.valid && flag_op_i.arg[FLG_SET_LSB + 5] && flag_op_i.arg[FLG_CLR_LSB + 5]
		&& !host_gp_wr) |=> gp_ff[5] != $past(gp_ff[5]);
	endproperty
	a_flag_op_tgl: assert property (p_flag_op_tgl) else $error("flag op toggle lost");

	property p_host_clear;
		(host_gp_wr && wdata_be[FLG_CLR_LSB + 3] && !wdata_be[FLG_SET_LSB + 3])
		|=> !gp_ff[3];
	endproperty
	a_host_clear: assert property (p_host_clear) else $error("host clear lost");

	property p_gp_quiet;
		!flag_op_i.valid && !host_gp_wr |=> $stable(gp_ff);
	endproperty
	a_gp_quiet: assert property (p_gp_quiet) else $error("flags moved on their own");

	property p_no_reply;
		msg_i.done && !msg_i.reply_seen |=> outc_ff.no_reply_flag && !outc_ff.good_block_flag;
	endproperty
	a_no_reply: assert property (p_no_reply) else $error("no reply not flagged");

	property p_late_reply;
		msg_i.done && msg_i.reply_seen && msg_i.reply_gap > tmo_cycles
		|=> outc_ff.no_reply_flag;
	endproperty
	a_late_reply: assert property (p_late_reply) else $error("late reply not flagged");

	property p_word_err;
		s_done_ok and msg_i.word_err |=> outc_ff.format_error_flag && !outc_ff.good_block_flag;
	endproperty
	a_word_err: assert property (p_word_err) else $error("word error not flagged");

	property p_addr_err;
		s_done_ok and (msg_i.status_word[ST_RT_HI:ST_RT_LO] != msg_i.rt_addr)
		|=> outc_ff.format_error_flag;
	endproperty
	a_addr_err: assert property (p_addr_err) else $error("address mismatch missed");

	property p_good_set;
		s_done_tx_clean |=> outc_ff.good_block_flag && !outc_ff.no_reply_flag;
	endproperty
	a_good_set: assert property (p_good_set) else $error("good block not set");

	property p_good_clr;
		msg_i.done && (msg_i.kind == MK_BC_TO_RT || msg_i.kind == MK_MODE_RX_DATA
		|| msg_i.kind == MK_MODE_NODATA) |=> !outc_ff.good_block_flag;
	endproperty
	a_good_clr: assert property (p_good_clr) else $error("good block not cleared");

	property p_masked_rsv;
		s_done_ok and (!msg_i.ctl_word[CTL_RSV_MASK] && msg_i.status_word[ST_RSV_LO])
		|=> outc_ff.masked_status_flag;
	endproperty
	a_masked_rsv: assert property (p_masked_rsv) else $error("reserved bit missed");

	property p_masked_msgerr;
		s_done_ok and (!msg_i.ctl_word[CTL_M_MSGERR] && msg_i.status_word[ST_MSGERR])
		|=> outc_ff.masked_status_flag;
	endproperty
	a_masked_msgerr: assert property (p_masked_msgerr) else $error("status bit missed");

	property p_masked_bcr;
		s_done_ok and (cfg_ff[CFG_BCAST_EN] && !msg_i.ctl_word[CTL_BCAST_MSK]
		&& msg_i.status_word[ST_BCR]) |=> outc_ff.masked_status_flag;
	endproperty
	a_masked_bcr: assert property (p_masked_bcr) else $error("broadcast bit missed");

	property p_outc_hold;
		!msg_i.done [*2] |=> $stable(outc_ff);
	endproperty
	a_outc_hold: assert property (p_outc_hold) else $error("outcome moved between messages");

	property p_outc_irq;
		msg_i.done |=> irq_stat_ff[IRQ_DONE] ##0
		(irq_stat_ff[IRQ_NO_REPLY] || !outc_ff.no_reply_flag);
	endproperty
	a_outc_irq: assert property (p_outc_irq) else $error("completion event lost");

	property p_bus_answer;
		req && bus_st_ff == BUS_IDLE |-> s_bus_access;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one wait cycle");

	// codes owned by other logic must never look like a valid test
	property p_known_off;
		(cond_sel_i[3:0] < CC_GP_FIRST || cond_sel_i[3:0] > CC_MASKED)
		|=> !cond_known_o && (cond_true_o == $past(cond_sel_i[CC_INV_BIT]));
	endproperty
	a_known_off: assert property (p_known_off) else $error("unknown code reported");

	property p_irq_w1c;
		wr_go && idx == IDX_IRQ_STAT && wdata_be[IRQ_DONE] && !msg_i.done
		|=> !irq_stat_ff[IRQ_DONE];
	endproperty
	a_irq_w1c: assert property (p_irq_w1c) else $error("done event not cleared");

	property p_mask_write;
		wr_go && idx == IDX_IRQ_MASK |=> irq_mask_ff == $past(wdata_be[IRQ_W-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_irq_no_reply;
		msg_i.done && !msg_i.reply_seen |=> irq_stat_ff[IRQ_NO_REPLY];
	endproperty
	a_irq_no_reply: assert property (p_irq_no_reply) else $error("no reply event lost");
endmodule

// ==== src/bccf_pkg.sv ====
// bccf_pkg: constants, types and register layout of the condition-code flag block
// How it works
// - low four bits select, bit 4 inverts
// - codes 8-11 follow last message outcome
// - codes 2-7 test general flags 2-7
// - flag op sets, clears or toggles flags
// - host write sets, clears or toggles flags
// - no reply sets no-reply flag
// - late reply past timeout sets no-reply
// - word validation error sets format error
// - wrong status address sets format error
// - clean transmit-type transfer sets good block
// - invalid or receive-type message clears good block
// - unmasked set status bit sets masked flag
// - reserved status bits unmasked set masked flag
// - enabled broadcast mask with received bit sets
package bccf_pkg;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned AVS_ADDR_W    = 10;
	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_BC_CFG    = 8'h32;
	localparam logic [7:0]  IDX_GP_FLAGS  = 8'h37;
	localparam logic [7:0]  IDX_IRQ_STAT  = 8'h40;
	localparam logic [7:0]  IDX_IRQ_MASK  = 8'h41;
	localparam logic [15:0] CFG_RST       = 16'h0000;
	localparam logic [5:0]  GP_RST        = 6'h00;
	localparam int unsigned CFG_TMO_HI    = 15;
	localparam int unsigned CFG_TMO_LO    = 14;
	localparam int unsigned CFG_BCAST_EN  = 0;
	// general flag argument: set bits 7:2, clear bits 15:10, both toggles
	localparam int unsigned FLG_SET_LSB   = 2;
	localparam int unsigned FLG_CLR_LSB   = 10;
	localparam int unsigned CC_INV_BIT    = 4;
	localparam logic [3:0]  CC_GP_FIRST   = 4'h2;
	localparam logic [3:0]  CC_GP_LAST    = 4'h7;
	localparam logic [3:0]  CC_NO_REPLY   = 4'h8;
	localparam logic [3:0]  CC_FMT_ERR    = 4'h9;
	localparam logic [3:0]  CC_GOOD_BLK   = 4'ha;
	localparam logic [3:0]  CC_MASKED     = 4'hb;
	// control word mask bits and the status bits they guard
	localparam int unsigned CTL_RSV_MASK  = 9;
	localparam int unsigned CTL_BCAST_MSK = 5;
	localparam int unsigned CTL_M_MSGERR  = 14;
	localparam int unsigned CTL_M_INSTR   = 13;
	localparam int unsigned CTL_M_SRVREQ  = 12;
	localparam int unsigned CTL_M_BUSY    = 11;
	localparam int unsigned CTL_M_SUBSYS  = 10;
	localparam int unsigned ST_MSGERR     = 10;
	localparam int unsigned ST_INSTR      = 9;
	localparam int unsigned ST_SRVREQ     = 8;
	localparam int unsigned ST_RSV_HI     = 7;
	localparam int unsigned ST_RSV_LO     = 5;
	localparam int unsigned ST_BCR        = 4;
	localparam int unsigned ST_BUSY       = 3;
	localparam int unsigned ST_SUBSYS     = 2;
	localparam int unsigned ST_RT_HI      = 15;
	localparam int unsigned ST_RT_LO      = 11;
	// reply timeout choices in microseconds
	localparam int unsigned TMO0_US       = 16;
	localparam int unsigned TMO1_US       = 32;
	localparam int unsigned TMO2_US       = 64;
	localparam int unsigned TMO3_US       = 128;
	localparam int unsigned IRQ_W         = 4;
	localparam int unsigned IRQ_DONE      = 0;
	localparam int unsigned IRQ_NO_REPLY  = 1;
	localparam int unsigned IRQ_FMT_ERR   = 2;
	localparam int unsigned IRQ_MASKED    = 3;

	typedef enum logic [2:0] {
		MK_BC_TO_RT, MK_RT_TO_BC, MK_RT_TO_RT, MK_MODE_TX_DATA, MK_MODE_RX_DATA, MK_MODE_NODATA
	} bccf_msg_kind_t;

	typedef enum logic {BUS_IDLE, BUS_ACK} bccf_bus_st_t;

	typedef struct packed {
		logic           done;
		bccf_msg_kind_t kind;
		logic           reply_seen;
		logic           word_err;
		logic [15:0]    reply_gap;
		logic [15:0]    status_word;
		logic [15:0]    ctl_word;
		logic [4:0]     rt_addr;
	} bccf_msg_t;

	typedef struct packed {
		logic valid;
		logic [15:0] arg;
	} bccf_flag_op_t;

	typedef struct packed {
		logic masked_status_flag;
		logic good_block_flag;
		logic format_error_flag;
		logic no_reply_flag;
	} bccf_outcome_t;
endpackage

// ==== src/bccf_msg_eval.sv ====
// bccf_msg_eval: outcome of one completed bus message
module bccf_msg_eval
	import bccf_pkg::*;
(
	input  wire bccf_msg_t     msg_i,
	input  wire logic [15:0]   tmo_cycles_i,
	input  wire logic          bcast_mask_en_i,
	output bccf_outcome_t      outc_o
);
	logic [15:0] sw;
	logic [15:0] cw;
	logic        reply_ok;
	logic        fmt;
	logic        stat_hit;
	logic        rsv_hit;
	logic        bcr_hit;
	logic        tx_kind;

	assign sw = msg_i.status_word;
	assign cw = msg_i.ctl_word;
	// a reply past the timeout counts as no reply at all
	assign reply_ok = msg_i.reply_seen && (msg_i.reply_gap <= tmo_cycles_i);
	assign fmt = reply_ok && (msg_i.word_err
		|| (sw[ST_RT_HI:ST_RT_LO] != msg_i.rt_addr));
	assign stat_hit = (!cw[CTL_M_MSGERR] && sw[ST_MSGERR])
		|| (!cw[CTL_M_INSTR] && sw[ST_INSTR])
		|| (!cw[CTL_M_SRVREQ] && sw[ST_SRVREQ])
		|| (!cw[CTL_M_BUSY] && sw[ST_BUSY])
		|| (!cw[CTL_M_SUBSYS] && sw[ST_SUBSYS]);
	assign rsv_hit = !cw[CTL_RSV_MASK] && (|sw[ST_RSV_HI:ST_RSV_LO]);
	assign bcr_hit = bcast_mask_en_i && !cw[CTL_BCAST_MSK] && sw[ST_BCR];
	assign tx_kind = (msg_i.kind == MK_RT_TO_BC) || (msg_i.kind == MK_RT_TO_RT)
		|| (msg_i.kind == MK_MODE_TX_DATA);

	assign outc_o.no_reply_flag      = !reply_ok;
	assign outc_o.format_error_flag  = fmt;
	// any other kind, or an invalid message, clears the flag
	assign outc_o.good_block_flag    = reply_ok && !fmt && tx_kind;
	// status masking needs a status word, so no reply means no match
	assign outc_o.masked_status_flag = reply_ok && (stat_hit || rsv_hit || bcr_hit);
endmodule

// ==== bench/bccf_rt_model.sv ====
// bccf_rt_model: remote terminal side, answers one command with a completed message
module bccf_rt_model
	import bccf_pkg::*;
(
	input  wire logic      sys_clk_i,
	input  wire logic      arst_n_i,
	input  wire logic      go_i,
	input  wire bccf_msg_t req_i,
	input  wire logic [3:0] delay_i,
	output bccf_msg_t      msg_o
);
	timeunit 1ns;
	timeprecision 100ps;
	bccf_msg_t  held_ff;
	logic [3:0] cnt_ff;
	logic       busy_ff;
	// released fields show the inverse of the last reply, never a stale copy
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_ff <= 1'b0;
			cnt_ff  <= 4'h0;
			held_ff <= '0;
			msg_o   <= '0;
		end else if (msg_o.done) begin
			msg_o      <= ~msg_o;
			msg_o.done <= 1'b0;
		end else if (go_i && !busy_ff) begin
			held_ff <= req_i;
			cnt_ff  <= delay_i;
			busy_ff <= 1'b1;
		end else if (busy_ff && cnt_ff == 4'h0) begin
			msg_o      <= held_ff;
			msg_o.done <= 1'b1;
			busy_ff    <= 1'b0;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end
endmodule

// ==== bench/test_bc_condition_code_flags.sv ====
// test_bc_condition_code_flags: self-checking bench for the condition-code flag block
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; $display("unexpected %0t: got %h expected %h", $time, got, exp); end end
module test_bc_condition_code_flags
	import bccf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic [9:0]    address = 10'h000;
	logic          read = 1'b0;
	logic          write = 1'b0;
	logic [31:0]   wdata = 32'h0;
	logic [31:0]   rdata;
	logic          waitreq;
	logic [4:0]    cond_sel = 5'h00;
	logic          cond_true;
	logic          cond_known;
	bccf_flag_op_t flag_op = '0;
	bccf_msg_t     msg;
	bccf_msg_t     req = '0;
	logic          go = 1'b0;
	logic [3:0]    dly = 4'h0;
	logic          irq;
	logic          cvld = 1'b0;
	logic          cvld_d = 1'b0;
	logic [31:0]   rd_q[$];
	logic [1:0]    cq[$];
	logic [31:0]   exp_rd;
	logic [1:0]    exp_c;
	logic [7:0]    gpm = 8'h00;
	logic [3:0]    oc = 4'h0;
	logic [3:0]    imask = 4'h0;
	logic [15:0]   tmo_tab [4] = '{16'h000a, 16'h0014, 16'h0028, 16'h0050};
	int            n_mismatch = 0;
	int            comparisons = 0;
	bccf_msg_t     m;

	always #2 clk = ~clk;

	bccf_core #(.TMO_CYC_0(16'h000a), .TMO_CYC_1(16'h0014), .TMO_CYC_2(16'h0028),
		.TMO_CYC_3(16'h0050)) u_bccf_core (
		.sys_clk_i(clk), .arst_n_i(rst_n), .avs_address_i(address), .avs_read_i(read),
		.avs_write_i(write), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .cond_sel_i(cond_sel),
		.cond_true_o(cond_true), .cond_known_o(cond_known), .flag_op_i(flag_op),
		.msg_i(msg), .irq_o(irq));

	bccf_rt_model u_bccf_rt_model (.sys_clk_i(clk), .arst_n_i(rst_n), .go_i(go),
		.req_i(req), .delay_i(dly), .msg_o(msg));

	// result watcher: oldest note against each answer as it appears
	always @(posedge clk) begin
		cvld_d <= cvld;
		if (read && waitreq === 1'b0) begin
			exp_rd = rd_q.pop_front();
			`CHK(rdata, exp_rd)
		end
		if (cvld_d) begin
			exp_c = cq.pop_front();
			`CHK({cond_known, cond_true}, exp_c)
		end
	end

	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hold request until waitrequest low, then release one cycle apart
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
		int n;
		n = 0;
		address <= {idx, 2'b00};
		write <= wr;
		read <= !wr;
		wdata <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		if (n >= 20) n_mismatch++;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [15:0] e);
		rd_q.push_back({16'h0000, e});
		bus(1'b0, idx, 16'h0000);
	endtask

	function automatic void apply(input logic [15:0] a);
		for (int n = 2; n < 8; n++) begin
			if (a[n] && a[n+8]) gpm[n] = !gpm[n];
			else if (a[n]) gpm[n] = 1'b1;
			else if (a[n+8]) gpm[n] = 1'b0;
		end
	endfunction

	function automatic logic [15:0] vec();
		return {4'h0, oc, gpm[7:2], 2'b00};
	endfunction

	task automatic fop(input logic [15:0] a);
		flag_op <= '{valid: 1'b1, arg: a};
		@(posedge clk);
		flag_op.valid <= 1'b0;
		apply(a);
		@(posedge clk);
	endtask

	task automatic hostflags(input logic [15:0] a);
		bus(1'b1, IDX_GP_FLAGS, a);
		apply(a);
		rd(IDX_GP_FLAGS, vec());
	endtask

	// every code with a random sense bit; codes outside 2-11 report unknown
	task automatic conds();
		logic inv;
		logic [15:0] v;
		v = vec();
		for (int c = 0; c < 16; c++) begin
			inv = 1'($urandom);
			cond_sel <= {inv, 4'(c)};
			cvld <= 1'b1;
			cq.push_back({1'(c >= 2 && c < 12), v[c] ^ inv});
			@(posedge clk);
		end
		cvld <= 1'b0;
	endtask

	task automatic message(input logic [1:0] ts, input logic ben);
		int n;
		logic ok, fe, mh;
		ok = m.reply_seen && m.reply_gap <= tmo_tab[ts];
		fe = ok && (m.word_err || m.status_word[ST_RT_HI:ST_RT_LO] != m.rt_addr);
		mh = (!m.ctl_word[CTL_M_MSGERR] && m.status_word[ST_MSGERR]) ||
			(!m.ctl_word[CTL_M_INSTR] && m.status_word[ST_INSTR]) ||
			(!m.ctl_word[CTL_M_SRVREQ] && m.status_word[ST_SRVREQ]) ||
			(!m.ctl_word[CTL_M_BUSY] && m.status_word[ST_BUSY]) ||
			(!m.ctl_word[CTL_M_SUBSYS] && m.status_word[ST_SUBSYS]) ||
			(!m.ctl_word[CTL_RSV_MASK] && |m.status_word[ST_RSV_HI:ST_RSV_LO]) ||
			(ben && !m.ctl_word[CTL_BCAST_MSK] && m.status_word[ST_BCR]);
		imask = 4'($urandom);
		bus(1'b1, IDX_BC_CFG, {ts, 13'h0000, ben});
		bus(1'b1, IDX_IRQ_MASK, {12'h000, imask});
		bus(1'b1, IDX_IRQ_STAT, 16'h000f);
		req <= m;
		dly <= 4'($urandom_range(9));
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		while (msg.done !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40) n_mismatch++;
		oc = {ok && mh, ok && !fe && m.kind inside {MK_RT_TO_BC, MK_RT_TO_RT, MK_MODE_TX_DATA},
			fe, !ok};
		@(negedge clk);
		`CHK(irq, |({oc[3], oc[1], oc[0], 1'b1} & imask))
		@(posedge clk);
		rd(IDX_GP_FLAGS, vec());
		rd(IDX_IRQ_STAT, {12'h000, oc[3], oc[1], oc[0], 1'b1});
		conds();
		fop(16'($urandom));
		rd(IDX_GP_FLAGS, vec());
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out();
	end

	initial begin
		void'($urandom(78));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(IDX_BC_CFG, CFG_RST);
		rd(IDX_GP_FLAGS, 16'h0000);
		rd(IDX_IRQ_STAT, 16'h0000);
		rd(IDX_IRQ_MASK, 16'h0000);
		bus(1'b1, 8'h3f, 16'hffff);
		rd(8'h3f, 16'h0000);
		bus(1'b1, IDX_BC_CFG, 16'hc001);
		rd(IDX_BC_CFG, 16'hc001);
		hostflags(16'h00fc);
		hostflags(16'hfcfc);
		hostflags(16'hfc00);
		for (int i = 0; i < 12; i++) begin
			if ($urandom_range(1)) hostflags(16'($urandom));
			else fop(16'($urandom));
			conds();
		end
		// late reply right at and one past each timeout choice
		for (int i = 0; i < 8; i++) begin
			m = '0;
			m.kind = MK_RT_TO_BC;
			m.reply_seen = 1'b1;
			m.ctl_word = 16'hffff;
			m.reply_gap = tmo_tab[i/2] + 16'(i%2);
			message(2'(i/2), 1'b0);
		end
		for (int i = 0; i < 40; i++) begin
			m.done = 1'b0;
			m.kind = bccf_msg_kind_t'(3'($urandom_range(5)));
			m.reply_seen = ($urandom_range(3) != 0);
			m.word_err = ($urandom_range(3) == 0);
			m.reply_gap = 16'($urandom_range(90));
			m.ctl_word = 16'($urandom);
			m.rt_addr = 5'($urandom);
			m.status_word = 16'($urandom);
			if ($urandom_range(3) != 0) m.status_word[ST_RT_HI:ST_RT_LO] = m.rt_addr;
			message(2'($urandom), 1'($urandom));
		end
		close_out();
	end
endmodule
